//--- pkg/dmr_map.svh
// Constants for the settings registers and the command link between the two ends.
// Assumes one memory clock shared by both ends and a single-rank device.
// Behaviour
// - Burst span four or eight, low field
// - Upper column bits pick aligned block, wrap inside
// - One bit picks sequential or interleaved order
// - Sequential order is start plus i modulo span
// - Interleaved order is start XOR i
// - Same burst span for reads and writes
// - Test select bit set blocks all other updates
// - Loop reset bit starts reset, then self-clears
// - Controller waits 200 clocks after loop reset
// - Auto precharge delayed by write recovery clocks
// - Controller computes recovery code, rounding up
// - Exit style bit: fast exit or frozen loop
// - Read latency three to six whole clocks
// - No half-clock latencies, no reserved codes
// - Early read held for posted extra latency
// - Extended settings only by load, persist
// - Extended load only idle, then load delay
// - Extended bit zero enables loop, then reset
// - Self refresh disables loop, exit re-enables, resets
// - After enable and reset, wait 200 clocks
// - Bank selects both low load main settings
// - Bank select low high writes extended settings
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH

`define DMR_SPAN_LSB 0
`define DMR_TYPE_BIT 3
`define DMR_LAT_LSB 4
`define DMR_TEST_BIT 7
`define DMR_LRST_BIT 8
`define DMR_WR_LSB 9
`define DMR_PDX_BIT 12
`define DMR_LOOP_BIT 0
`define DMR_AL_LSB 3
`define DMR_APRE_BIT 10

`define DMR_SPAN_FOUR 3'h2
`define DMR_SPAN_EIGHT 3'h3
`define DMR_LOOP_ON 1'h0
`define DMR_BANK_MAIN 2'h0
`define DMR_BANK_EXT 2'h1

`define DMR_RCW_LOAD 3'h0
`define DMR_RCW_REF 3'h1
`define DMR_RCW_PRE 3'h2
`define DMR_RCW_ACT 3'h3
`define DMR_RCW_WRITE 3'h4
`define DMR_RCW_READ 3'h5
`define DMR_RCW_NOP 3'h7

`define DMR_LOCK_CYCLES 8'hC8
`define DMR_LOAD_DELAY_CYCLES 3'h2
`define DMR_CLK_PERIOD_NS 50
`define DMR_WR_TIME_NS 15
`define DMR_WR_CYCLES ((`DMR_WR_TIME_NS + `DMR_CLK_PERIOD_NS - 1) / `DMR_CLK_PERIOD_NS)

`define DMR_REG_CMD 4'h0
`define DMR_REG_ADDR 4'h1
`define DMR_REG_STATUS 4'h2

`endif

//--- pkg/dmr_pkg.sv
// Types shared by the memory end and the controller end.
// Assumes dmr_map.svh for all numeric constants.
package dmr_pkg;
  typedef enum logic [3:0] {
    DMR_CMD_NOP, DMR_CMD_LOAD, DMR_CMD_ACTIVATE, DMR_CMD_READ, DMR_CMD_WRITE,
    DMR_CMD_WRITE_AP, DMR_CMD_PRECHARGE_ALL, DMR_CMD_SREF_ENTER, DMR_CMD_SREF_EXIT
  } dmr_command_type;

  typedef enum logic [1:0] {
    DMR_AWAKE, DMR_ACTIVE_PD, DMR_PRECHARGE_PD, DMR_SELF_REFRESH
  } dmr_power_saving_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic ap;
    logic [1:0] bank;
    logic [9:0] col;
  } dmr_column_cmd_type;
endpackage

//--- pkg/dmr_link_if.sv
// Command and address link between the memory controller and the memory.
// Assumes both ends run on the same memory clock; no clocking block.
interface dmr_link_if (
  input wire logic ref_clk // Memory clock.
);
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  logic rd_valid;

  modport device (input ref_clk, input cke, input cs_n, input ras_n, input cas_n, input we_n,
    input ba, input addr, output rd_valid);
  modport ctrl (input ref_clk, output cke, output cs_n, output ras_n, output cas_n,
    output we_n, output ba, output addr, input rd_valid);
endinterface

//--- src/dmr_device.sv
// Memory end: main and extended settings, burst column order, read latency,
// write recovery, loop reset and power-saving states.
// Assumes the controller keeps the timing it owns (load delay, loop lock wait).
`include "dmr_map.svh"

module dmr_device
  import dmr_pkg::*;
(
  input wire logic ref_clk, // Memory clock.
  input wire logic nrst, // Asynchronous reset, active low.
  dmr_link_if.device link, // Command and address pins.
  output logic [9:0] burst_col, // Column being accessed.
  output logic burst_col_valid, // Burst_col holds a column this cycle.
  output logic burst_is_write, // Current burst is a write.
  output logic read_data_start, // First read data beat.
  output logic auto_precharge_pulse, // Internal precharge issued.
  output logic loop_enabled, // Delay-locked loop running.
  output logic loop_reset_pulse, // Loop reset issued.
  output logic loop_locked, // Lock wait after reset over.
  output logic loop_frozen, // Loop frozen in slow-exit power-down.
  output logic test_mode, // Vendor test select was written.
  output dmr_power_saving_state_type power_state, // Power-saving state.
  output logic [12:0] main_settings, // Main settings register.
  output logic [12:0] ext_settings // Extended settings register.
);

  function automatic logic [9:0] burst_col_at(input logic [9:0] start, input logic [2:0] idx,
                                              input logic span8, input logic ilv);
    logic [2:0] mask;
    logic [2:0] low;
    mask = span8 ? 3'h7 : 3'h3;
    low = ilv ? (start[2:0] ^ idx) : 3'(start[2:0] + idx);
    burst_col_at = (start & ~{7'h0, mask}) | {7'h0, low & mask};
  endfunction

  logic sel;
  logic [2:0] rcw;
  logic is_load;
  logic is_act;
  logic is_pre;
  logic is_rd;
  logic is_wr;
  logic sref_enter;
  logic sref_exit;
  logic span8;
  logic ilv;
  logic [2:0] lat_field;
  logic [2:0] cl_eff;
  logic [2:0] al_field;
  logic [2:0] al_eff;
  logic [2:0] al_tap;
  logic [2:0] wr_field;
  logic [3:0] wr_cycles;
  dmr_column_cmd_type new_cmd;
  dmr_column_cmd_type exec_cmd;
  dmr_column_cmd_type al_slot [0:3];
  logic [9:0] b_start;
  logic [2:0] b_idx;
  logic b_active;
  logic b_ap;
  logic [1:0] b_bank;
  logic b_last;
  logic [3:0] wr_left;
  logic [1:0] wr_bank;
  logic [7:0] rd_pipe;
  logic rd_tap;
  logic [1:0] rd_left;
  logic [3:0] bank_open;
  logic loop_reset_req;
  logic [7:0] lock_left;

  assign sel = ~link.cs_n & link.cke;
  assign rcw = {link.ras_n, link.cas_n, link.we_n};
  assign is_load = sel && rcw == `DMR_RCW_LOAD;
  assign is_act = sel && rcw == `DMR_RCW_ACT;
  assign is_pre = sel && rcw == `DMR_RCW_PRE;
  assign is_rd = sel && rcw == `DMR_RCW_READ;
  assign is_wr = sel && rcw == `DMR_RCW_WRITE;
  assign sref_enter = ~link.cs_n && ~link.cke && rcw == `DMR_RCW_REF
                      && power_state == DMR_AWAKE;
  assign sref_exit = power_state == DMR_SELF_REFRESH && link.cke;

  // Reserved encodings fall back to a legal value so the datapath stays defined.
  assign span8 = main_settings[`DMR_SPAN_LSB +: 3] == `DMR_SPAN_EIGHT;
  assign ilv = main_settings[`DMR_TYPE_BIT];
  assign lat_field = main_settings[`DMR_LAT_LSB +: 3];
  assign cl_eff = (lat_field >= 3'h3 && lat_field <= 3'h6) ? lat_field : 3'h3;
  assign al_field = ext_settings[`DMR_AL_LSB +: 3];
  assign al_eff = (al_field > 3'h4) ? 3'h4 : al_field;
  assign al_tap = al_eff - 3'h1;
  assign wr_field = main_settings[`DMR_WR_LSB +: 3];
  assign wr_cycles = (wr_field >= 3'h1 && wr_field <= 3'h5) ? {1'h0, wr_field} + 4'h1 : 4'h6;
  assign loop_reset_req = main_settings[`DMR_LRST_BIT] || sref_exit;

  assign new_cmd = '{valid: is_rd | is_wr, write: is_wr, ap: link.addr[`DMR_APRE_BIT],
                     bank: link.ba, col: link.addr[9:0]};
  // A read or write may arrive early and waits here for the posted extra latency.
  assign exec_cmd = (al_eff == 3'h0) ? new_cmd : al_slot[al_tap[1:0]];
  assign b_last = b_active && b_idx == (span8 ? 3'h7 : 3'h3);
  assign rd_tap = rd_pipe[3'(cl_eff - 3'h2)];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        al_slot[i] <= '0;
      end
    end else begin
      al_slot[0] <= new_cmd;
      for (int i = 1; i < 4; i++) begin
        al_slot[i] <= al_slot[i - 1];
      end
    end
  end

  // Settings registers; a load wins over the self-clearing of the reset bit.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      main_settings <= '0;
      ext_settings <= '0;
      test_mode <= 1'h0;
    end else begin
      if (is_load && link.ba == `DMR_BANK_MAIN) begin
        if (link.addr[`DMR_TEST_BIT]) begin
          test_mode <= 1'h1;
        end else begin
          main_settings <= link.addr;
          test_mode <= 1'h0;
        end
      end else if (main_settings[`DMR_LRST_BIT]) begin
        main_settings[`DMR_LRST_BIT] <= 1'h0;
      end
      if (is_load && link.ba == `DMR_BANK_EXT) begin
        ext_settings <= link.addr;
      end
    end
  end

  // One column per clock, ordered within the aligned block.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      burst_col <= '0;
      burst_col_valid <= 1'h0;
      burst_is_write <= 1'h0;
      b_start <= '0;
      b_idx <= '0;
      b_active <= 1'h0;
      b_ap <= 1'h0;
      b_bank <= '0;
    end else if (exec_cmd.valid) begin
      burst_col <= burst_col_at(exec_cmd.col, 3'h0, span8, ilv);
      burst_col_valid <= 1'h1;
      burst_is_write <= exec_cmd.write;
      b_start <= exec_cmd.col;
      b_idx <= 3'h1;
      b_active <= 1'h1;
      b_ap <= exec_cmd.ap;
      b_bank <= exec_cmd.bank;
    end else if (b_active) begin
      burst_col <= burst_col_at(b_start, b_idx, span8, ilv);
      burst_col_valid <= 1'h1;
      b_idx <= b_idx + 3'h1;
      b_active <= ~b_last;
    end else begin
      burst_col_valid <= 1'h0;
    end
  end

  // Write recovery counts from the last column of a write burst.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_left <= '0;
      wr_bank <= '0;
      auto_precharge_pulse <= 1'h0;
    end else begin
      auto_precharge_pulse <= (b_last && b_ap && !burst_is_write) || wr_left == 4'h1;
      if (b_last && b_ap && burst_is_write) begin
        wr_left <= wr_cycles;
        wr_bank <= b_bank;
      end else if (wr_left != 4'h0) begin
        wr_left <= wr_left - 4'h1;
      end
    end
  end

  // Read data follows the internal command by the read latency.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pipe <= '0;
      rd_left <= '0;
      read_data_start <= 1'h0;
      link.rd_valid <= 1'h0;
    end else begin
      rd_pipe <= {rd_pipe[6:0], exec_cmd.valid && !exec_cmd.write};
      read_data_start <= rd_tap;
      link.rd_valid <= rd_tap || rd_left != 2'h0;
      if (rd_tap) begin
        rd_left <= span8 ? 2'h3 : 2'h1;
      end else if (rd_left != 2'h0) begin
        rd_left <= rd_left - 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bank_open <= '0;
    end else begin
      if (is_act) begin
        bank_open[link.ba] <= 1'h1;
      end else if (is_pre) begin
        if (link.addr[`DMR_APRE_BIT]) begin
          bank_open <= '0;
        end else begin
          bank_open[link.ba] <= 1'h0;
        end
      end
      if (b_last && b_ap && !burst_is_write) begin
        bank_open[b_bank] <= 1'h0;
      end else if (wr_left == 4'h1) begin
        bank_open[wr_bank] <= 1'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      power_state <= DMR_AWAKE;
    end else begin
      case (power_state)
        DMR_AWAKE: begin
          if (sref_enter) begin
            power_state <= DMR_SELF_REFRESH;
          end else if (!link.cke) begin
            power_state <= (bank_open != 4'h0) ? DMR_ACTIVE_PD : DMR_PRECHARGE_PD;
          end
        end
        DMR_ACTIVE_PD, DMR_PRECHARGE_PD: begin
          if (link.cke) begin
            power_state <= DMR_AWAKE;
          end
        end
        DMR_SELF_REFRESH: begin
          if (link.cke) begin
            power_state <= DMR_AWAKE;
          end
        end
        default: power_state <= DMR_AWAKE;
      endcase
    end
  end

  // Loop status; lock is only reported, waiting for it is the controller's job.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      loop_enabled <= 1'h0;
      loop_reset_pulse <= 1'h0;
      loop_locked <= 1'h0;
      loop_frozen <= 1'h0;
      lock_left <= '0;
    end else begin
      loop_enabled <= ext_settings[`DMR_LOOP_BIT] == `DMR_LOOP_ON
                      && power_state != DMR_SELF_REFRESH;
      loop_reset_pulse <= loop_reset_req;
      loop_frozen <= power_state == DMR_ACTIVE_PD && main_settings[`DMR_PDX_BIT];
      if (loop_reset_req) begin
        lock_left <= `DMR_LOCK_CYCLES;
        loop_locked <= 1'h0;
      end else if (lock_left != 8'h0) begin
        lock_left <= lock_left - 8'h1;
        loop_locked <= lock_left == 8'h1;
      end
    end
  end

endmodule // dmr_device

//--- src/dmr_controller.sv
// Controller end: takes commands over a plain register port and drives the link,
// keeping load delay, loop lock wait and legal main settings codes.
// Assumes the register master follows the one-cycle strobe protocol.
`include "dmr_map.svh"

module dmr_controller
  import dmr_pkg::*;
(
  input wire logic ref_clk, // Memory clock.
  input wire logic nrst, // Asynchronous reset, active low.
  dmr_link_if.ctrl link, // Command and address pins.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [15:0] reg_rdata // Read data, one cycle after reg_rd.
);

  localparam int WR_CYC = `DMR_WR_CYCLES;
  localparam logic [2:0] WR_CODE = (WR_CYC < 2) ? 3'h1 : 3'(WR_CYC - 1);

  logic [12:0] stage_addr;
  logic [1:0] stage_bank;
  logic [2:0] mrd_left;
  logic [7:0] lock_left;
  logic [4:0] burst_left;
  logic [3:0] banks;
  logic in_sref;
  logic reset_owed;
  logic err_refused;
  logic err_encoding;
  logic span8_cur;
  logic [2:0] cl_cur;
  logic [2:0] al_cur;
  logic issue;
  dmr_command_type cmd;
  logic [12:0] load_word;
  logic main_legal;
  logic ext_legal;
  logic allowed;
  logic [4:0] guard;

  assign cmd = dmr_command_type'(reg_wdata[3:0]);
  assign issue = reg_wr && reg_addr == `DMR_REG_CMD;
  assign load_word = (stage_bank == `DMR_BANK_MAIN)
                     ? {stage_addr[12], WR_CODE, stage_addr[8:0]} : stage_addr;
  assign main_legal = !stage_addr[`DMR_TEST_BIT]
    && (stage_addr[2:0] == `DMR_SPAN_FOUR || stage_addr[2:0] == `DMR_SPAN_EIGHT)
    && stage_addr[6:4] >= 3'h3 && stage_addr[6:4] <= 3'h6;
  assign ext_legal = stage_addr[5:3] <= 3'h4;
  assign guard = {2'h0, al_cur} + {2'h0, cl_cur} + (span8_cur ? 5'h4 : 5'h2)
                 + ((cmd == DMR_CMD_WRITE_AP) ? {1'h0, 4'(WR_CODE) + 4'h1} : 5'h0);

  always_comb begin
    allowed = mrd_left == 3'h0 && (!in_sref || cmd == DMR_CMD_SREF_EXIT);
    case (cmd)
      DMR_CMD_LOAD: allowed = allowed && banks == 4'h0 && burst_left == 5'h0;
      DMR_CMD_READ: allowed = allowed && lock_left == 8'h0;
      DMR_CMD_SREF_ENTER: allowed = allowed && banks == 4'h0 && burst_left == 5'h0;
      DMR_CMD_SREF_EXIT: allowed = in_sref;
      default: allowed = allowed;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage_addr <= '0;
      stage_bank <= '0;
    end else if (reg_wr && reg_addr == `DMR_REG_ADDR) begin
      stage_addr <= reg_wdata[12:0];
      stage_bank <= reg_wdata[14:13];
    end
  end

  // Link pins fall back to no-operation every cycle after a command.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      link.cke <= 1'h1;
      link.cs_n <= 1'h1;
      {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_NOP;
      link.ba <= '0;
      link.addr <= '0;
    end else begin
      link.cs_n <= 1'h1;
      {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_NOP;
      if (issue && allowed) begin
        link.cs_n <= 1'h0;
        link.ba <= stage_bank;
        link.addr <= stage_addr;
        case (cmd)
          DMR_CMD_LOAD: begin
            {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_LOAD;
            link.addr <= load_word;
            // A main word with the test select or a reserved code never reaches the memory.
            if (stage_bank == `DMR_BANK_MAIN && !main_legal) link.cs_n <= 1'h1;
          end
          DMR_CMD_ACTIVATE: {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_ACT;
          DMR_CMD_READ: {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_READ;
          DMR_CMD_WRITE: {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_WRITE;
          DMR_CMD_WRITE_AP: begin
            {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_WRITE;
            link.addr[`DMR_APRE_BIT] <= 1'h1;
          end
          DMR_CMD_PRECHARGE_ALL: begin
            {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_PRE;
            link.addr[`DMR_APRE_BIT] <= 1'h1;
          end
          DMR_CMD_SREF_ENTER: begin
            {link.ras_n, link.cas_n, link.we_n} <= `DMR_RCW_REF;
            link.cke <= 1'h0;
          end
          DMR_CMD_SREF_EXIT: begin
            link.cs_n <= 1'h1;
            link.cke <= 1'h1;
          end
          default: link.cs_n <= 1'h1;
        endcase
      end
    end
  end

  // Bookkeeping of what the device is doing; encoding faults are flagged apart from refusals.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mrd_left <= '0;
      lock_left <= '0;
      burst_left <= '0;
      banks <= '0;
      in_sref <= 1'h0;
      reset_owed <= 1'h0;
      err_refused <= 1'h0;
      err_encoding <= 1'h0;
      span8_cur <= 1'h0;
      cl_cur <= 3'h3;
      al_cur <= '0;
    end else begin
      if (mrd_left != 3'h0) mrd_left <= mrd_left - 3'h1;
      if (lock_left != 8'h0) lock_left <= lock_left - 8'h1;
      if (burst_left != 5'h0) burst_left <= burst_left - 5'h1;
      if (issue) begin
        err_refused <= !allowed;
        err_encoding <= 1'h0;
      end
      if (issue && allowed) begin
        case (cmd)
          DMR_CMD_LOAD: begin
            mrd_left <= `DMR_LOAD_DELAY_CYCLES;
            if (stage_bank == `DMR_BANK_MAIN && main_legal) begin
              span8_cur <= stage_addr[2:0] == `DMR_SPAN_EIGHT;
              cl_cur <= stage_addr[6:4];
              if (stage_addr[`DMR_LRST_BIT]) begin
                lock_left <= `DMR_LOCK_CYCLES;
                reset_owed <= 1'h0;
              end
            end else if (stage_bank == `DMR_BANK_EXT && ext_legal) begin
              al_cur <= stage_addr[5:3];
              if (stage_addr[`DMR_LOOP_BIT] == `DMR_LOOP_ON) reset_owed <= 1'h1;
            end
            err_encoding <= (stage_bank == `DMR_BANK_MAIN && !main_legal)
                            || (stage_bank == `DMR_BANK_EXT && !ext_legal);
          end
          DMR_CMD_ACTIVATE: banks[stage_bank] <= 1'h1;
          DMR_CMD_READ, DMR_CMD_WRITE: burst_left <= guard;
          DMR_CMD_WRITE_AP: begin
            burst_left <= guard;
            banks[stage_bank] <= 1'h0;
          end
          DMR_CMD_PRECHARGE_ALL: banks <= '0;
          DMR_CMD_SREF_ENTER: in_sref <= 1'h1;
          DMR_CMD_SREF_EXIT: begin
            in_sref <= 1'h0;
            lock_left <= `DMR_LOCK_CYCLES;
          end
          default: banks <= banks;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == `DMR_REG_STATUS) begin
      reg_rdata <= {7'h0, link.rd_valid, err_encoding, err_refused, reset_owed, in_sref,
                    banks != 4'h0, burst_left != 5'h0, lock_left != 8'h0, mrd_left != 3'h0};
    end else if (reg_rd && reg_addr == `DMR_REG_ADDR) begin
      reg_rdata <= {1'h0, stage_bank, stage_addr};
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // dmr_controller

//--- test/dmr_link_asserts.sv
// Checker for the command link between the controller end and the memory end.
// Assumes it is instantiated beside the link interface and sees its plain signals.
module dmr_link_asserts (
  input wire logic ref_clk, // Memory clock.
  input wire logic nrst, // Reset, active low.
  input wire logic cke, // Clock enable.
  input wire logic cs_n, // Chip select, active low.
  input wire logic ras_n, // Command code bit.
  input wire logic cas_n, // Command code bit.
  input wire logic we_n, // Command code bit.
  input wire logic [1:0] ba, // Bank select.
  input wire logic [12:0] addr, // Address or settings word.
  input wire logic rd_valid // Read data window.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cmd, load, main_load, read, span8;
  logic [2:0] cl, al;
  logic [3:0] rcnt;
  logic [7:0] lock;
  assign cmd = !cs_n && cke;
  assign load = cmd && {ras_n, cas_n, we_n} == 3'h0;
  assign main_load = load && ba == 2'h0;
  assign read = cmd && {ras_n, cas_n, we_n} == 3'h5;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Reserved latency codes are read as three, matching the memory end.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      span8 <= 1'h0;
      cl <= 3'h3;
      al <= 3'h0;
    end else if (main_load) begin
      span8 <= addr[2:0] == 3'h3;
      cl <= (addr[6:4] < 3'h3 || addr[6:4] > 3'h6) ? 3'h3 : addr[6:4];
    end else if (load && ba == 2'h1) begin
      al <= (addr[5:3] > 3'h4) ? 3'h4 : addr[5:3];
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) lock <= 8'h00;
    else if ((main_load && addr[8]) || (cke && !$past(cke))) lock <= 8'hC7;
    else if (lock != 8'h00) lock <= lock - 8'h01;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rcnt <= 4'h0;
    else if (read) rcnt <= {1'h0, cl} + {1'h0, al};
    else if (rcnt != 4'h0) rcnt <= rcnt - 4'h1;
  end
  a_load_gap: assert property (load |=> !load)
    else $error("settings loads too close");
  a_lock_wait: assert property (read |-> lock == 8'h00)
    else $error("read issued during loop lock wait");
  a_test_clear: assert property (main_load |-> !addr[7])
    else $error("main load with test select set");
  a_wr_code: assert property (main_load |-> addr[11:9] == 3'h1)
    else $error("write recovery code wrong");
  a_span_eight: assert property ($rose(rd_valid) && span8 |-> rd_valid [*4] ##1 !rd_valid)
    else $error("read window not four cycles");
  a_span_four: assert property ($rose(rd_valid) && !span8 |-> rd_valid [*2] ##1 !rd_valid)
    else $error("read window not two cycles");
  a_read_lat: assert property (rcnt == 4'h1 |-> $rose(rd_valid))
    else $error("read data not at programmed latency");
  a_bank_code: assert property (load |-> !ba[1])
    else $error("load with unsupported bank select");
  a_sref_quiet: assert property (!cke && $past(!cke) |-> cs_n)
    else $error("command during self refresh");
endmodule // dmr_link_asserts

//--- test/tb_ddr2_mode_register_burst_logic.sv
// Self-checking bench: controller end and memory end joined by the link interface.
// Assumes a 20 MHz clock and software access through the controller's register port.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module tb_ddr2_mode_register_burst_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, st;
  logic [9:0] burst_col;
  logic burst_col_valid, loop_enabled, loop_locked;
  logic burst_is_write, read_data_start, auto_precharge_pulse, test_mode;
  logic [1:0] power_state;
  int t0 = 0, t1 = 0, t2 = 0, tl = 0;
  logic [12:0] main_settings, ext_settings;
  logic [31:0] seed = 32'h0000002A;
  logic [9:0] q[$];
  int n_errors = 0, comparisons = 0, cycles = 0;
  dmr_link_if link (.ref_clk(ref_clk));
  dmr_device dmr_device_i (.ref_clk(ref_clk), .nrst(nrst), .link(link), .burst_col(burst_col),
    .burst_col_valid(burst_col_valid), .burst_is_write(burst_is_write),
    .read_data_start(read_data_start), .auto_precharge_pulse(auto_precharge_pulse),
    .loop_enabled(loop_enabled), .loop_reset_pulse(),
    .loop_locked(loop_locked), .loop_frozen(), .test_mode(test_mode),
    .power_state(power_state),
    .main_settings(main_settings), .ext_settings(ext_settings));
  dmr_controller dmr_controller_i (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  dmr_link_asserts dmr_link_asserts_i (.ref_clk(ref_clk), .nrst(nrst), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .addr(link.addr), .rd_valid(link.rd_valid));
  initial forever #25 ref_clk = ~ref_clk;
  // The cycle ceiling is well above the expected run, so only a hang reaches it.
  always @(posedge ref_clk) begin
    cycles++;
    if (burst_col_valid && q.size() == 0) t0 = cycles;
    if (burst_col_valid) q.push_back(burst_col);
    if (burst_col_valid) tl = cycles;
    if (read_data_start) t1 = cycles;
    if (auto_precharge_pulse) t2 = cycles;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] exp_col(logic [9:0] c, int bl, logic ilv, int i);
    return 10'((c & ~(bl - 1)) | ((ilv ? (c ^ i) : (c + i)) & (bl - 1)));
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [14:0] a);
    wr(4'h1, {1'h0, a});
    wr(4'h0, {12'h000, op});
    repeat (3) @(posedge ref_clk);
    for (int k = 0; k < 400; k++) begin
      rd(4'h2, st);
      if (st[2:0] == 3'h0) break;
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    logic [12:0] m;
    logic [9:0] c;
    logic ilv, s8;
    logic [2:0] lat;
    int bl;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'h1;
    cmd(4'h6, 15'h0400);
    cmd(4'h1, 15'h2000);
    `CHK(ext_settings, 13'h0000)
    `CHK(loop_enabled, 1'h1)
    cmd(4'h1, 15'h0142);
    `CHK(main_settings, 13'h0242)
    rd(4'h1, st);
    `CHK(loop_locked, 1'h1)
    `CHK(st, 16'h0142)
    rd(4'hF, st);
    `CHK(st, 16'h0000)
    for (int t = 0; t < 12; t++) begin
      s8 = rnd() % 2;
      ilv = rnd() % 2;
      c = 10'(rnd());
      if (t < 2) begin
        s8 = 1'h1;
        ilv = t == 0;
        c = t == 0 ? 10'h005 : 10'h3F9;
      end
      bl = s8 ? 8 : 4;
      lat = 3'(3 + rnd() % 4);
      m = {6'h00, lat, ilv, s8 ? 3'h3 : 3'h2};
      cmd(4'h1, {2'h0, m});
      `CHK(main_settings, m | 13'h0200)
      cmd(4'h2, 15'h0000);
      q.delete();
      cmd((t % 2 == 0) ? 4'h3 : ((t == 1) ? 4'h5 : 4'h4), {5'h00, c});
      `CHK(q.size(), bl)
      foreach (q[i]) `CHK(q[i], exp_col(c, bl, ilv, i))
      `CHK(burst_is_write, 1'(t % 2))
      // Read data trails the first column by the latency less the column's own register.
      if (t % 2 == 0) `CHK(t1 - t0, lat - 1)
      // The controller programs the shortest recovery, two clocks.
      if (t == 1) `CHK(t2 - tl, 2)
      cmd(4'h6, 15'h0400);
    end
    cmd(4'h1, 15'h0080);
    `CHK(st[7:6], 2'h2)
    `CHK(main_settings, m | 13'h0200)
    `CHK(test_mode, 1'h0)
    cmd(4'h7, 15'h0000);
    `CHK(loop_enabled, 1'h0)
    `CHK(power_state, 2'h3)
    cmd(4'h8, 15'h0000);
    `CHK(loop_enabled, 1'h1)
    `CHK(power_state, 2'h0)
    report_and_stop();
  end
endmodule // tb_ddr2_mode_register_burst_logic
